/* verilog/slac_core.sv */
// card security level tracking and command admission
// assumes reader events arrive as command words over avalon-mm
//
// Summary of operation
// - after layer-4 activation accept apdu select A4h and external-auth 82h
// - native commands also accepted apdu-wrapped, but only after layer 4
// - card or sector level changes only go upward, never downward
// - mixed sectors take legacy and aes operations; never card-wide
// - card acts at the lowest level any sector holds
// - anticollision reports card level, or highest with mixed as aes when option set
// - card level rises by itself once all sectors reach it
// - personalization allows genuineness, version, writes, commit; layer 3 or 4
// - anticollision needs one cascade for 4-byte id, two for 7-byte
// - committed level takes effect only after reactivation
// - commit needs config and root keys, switch key unless going aes
// - legacy stream-cipher auth enters legacy-authenticated state
// - aes card-auth-key auth at legacy level layer 3 only, then legacy auth needed again
// - legacy level: genuineness, aes messaging, updates, switch need layer 4
// - switch key auth accepted as first or following authentication
// - switch key auth moves to aes level after reactivation
// - mixed sectors: legacy commands at layer 3, aes at layer 4
// - legacy level refuses layer-4 activation when configured off
// - aes level: layer 4 only, no legacy data or stream cipher
// - aes level: layer 3, layer 4, then aes auth for data
// - aes auth yields separate encryption and mac session keys
// - layer 4 for all in aes; limited command set in legacy
`timescale 1ns/10ps
module slac_core
  import slac_pkg::*;
#(
  parameter int unsigned NSEC = 32
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [DATA_W-1:0] writedata,
  input  wire logic [3:0]        byteenable,
  output logic      [DATA_W-1:0] readdata,
  output logic                   waitrequest,
  // card state view
  output logic      [1:0]        card_level,
  output logic      [1:0]        atq_level,
  output logic                   l4_active,
  output logic                   cmd_accept,
  output logic                   cmd_reject
);

  localparam int unsigned SW = $clog2(NSEC);

  logic              wait_r;
  logic [DATA_W-1:0] rdata_r;
  logic              uid7_r;
  logic              atqhi_r;
  logic [5:0]        secsel_r;
  slac_layer_t       layer_r;
  slac_layer_t       layer_nxt;
  slac_auth_t        auth_r;
  slac_auth_t        auth_nxt;
  logic [1:0]        sess_r;
  logic [1:0]        card_lvl_r;
  logic              pend_r;
  logic [1:0]        pend_lvl_r;
  logic [2:0]        keys_r;
  logic              l4dis_r;
  logic [1:0]        atq_r;
  logic              ok_r;
  logic              err_r;
  logic              acc_r;
  logic              rej_r;
  logic [1:0]        sec_lvl_r [NSEC];

  slac_cmd_t         c;
  slac_stat_t        stat;
  logic              ex;
  logic              taken;
  logic              ok_c;
  logic              pend_c;
  logic [1:0]        pend_lvl_c;
  logic              sw_c;
  logic              lcfg_c;
  logic              sess_c;
  logic [3:0]        kw_c;
  logic              apply_c;
  logic [1:0]        min_c;
  logic [1:0]        max_c;
  logic [1:0]        sl;
  logic              sec_ok;
  logic              sl_leg;
  logic              sl_aes;
  logic              pers;
  logic              leg;
  logic              aes;
  logic              l3;
  logic              l4;
  logic              act;

  assign c     = slac_cmd_t'(writedata[$bits(slac_cmd_t)-1:0]);
  assign taken = (read || write) && !wait_r;
  assign ex    = write && !wait_r && address == OFF_CMD
                 && byteenable == 4'hF;

  assign readdata    = rdata_r;
  assign waitrequest = wait_r;
  assign card_level  = card_lvl_r;
  assign atq_level   = atq_r;
  assign l4_active   = layer_r[2];
  assign cmd_accept  = acc_r;
  assign cmd_reject  = rej_r;

  // one wait cycle per access, then one cycle low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wait_r <= 1'h1;
    end else begin
      wait_r <= !((read || write) && wait_r);
    end
  end

  always_comb begin
    stat.sess  = sess_r;
    stat.atq   = atq_r;
    stat.plvl  = pend_lvl_r;
    stat.pend  = pend_r;
    stat.l4dis = l4dis_r;
    stat.auth  = auth_r;
    stat.layer = layer_r;
    stat.card  = card_lvl_r;
    stat.err   = err_r;
    stat.ok    = ok_r;
  end

  // read data captured in the wait cycle, stands at the taking edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 32'h0;
    end else if (read && wait_r) begin
      unique case (address)
        OFF_CTRL:   rdata_r <= {30'h0, atqhi_r, uid7_r};
        OFF_STAT:   rdata_r <= {{STAT_PAD{1'h0}}, stat};
        OFF_SECSEL: rdata_r <= {26'h0, secsel_r};
        OFF_SECLVL: rdata_r <= (32'(secsel_r) < NSEC) ?
                      {30'h0, sec_lvl_r[secsel_r[SW-1:0]]} : 32'h0;
        default:    rdata_r <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      uid7_r   <= CTRL_RST;
      atqhi_r  <= CTRL_RST;
      secsel_r <= SECSEL_RST;
    end else if (taken && write && byteenable[0]) begin
      if (address == OFF_CTRL) begin
        uid7_r  <= writedata[CTRL_UID7];
        atqhi_r <= writedata[CTRL_ATQHI];
      end
      if (address == OFF_SECSEL) begin
        secsel_r <= writedata[5:0];
      end
    end
  end

  // lowest and highest sector level
  always_comb begin
    min_c = LV_AES;
    max_c = LV_PERS;
    for (int i = 0; i < NSEC; i++) begin
      if (sec_lvl_r[i] < min_c) begin
        min_c = sec_lvl_r[i];
      end
      if (sec_lvl_r[i] > max_c) begin
        max_c = sec_lvl_r[i];
      end
    end
  end

  assign pers   = card_lvl_r == LV_PERS;
  assign leg    = card_lvl_r == LV_LEG;
  assign aes    = card_lvl_r == LV_AES;
  assign l3     = layer_r == LY_L3;
  assign l4     = layer_r == LY_L4;
  assign act    = l3 || l4;
  assign sec_ok = 32'(c.sec) < NSEC;
  assign sl     = sec_ok ? sec_lvl_r[c.sec[SW-1:0]] : LV_PERS;
  assign sl_leg = sec_ok && (sl == LV_LEG || sl == LV_MIX);
  assign sl_aes = sec_ok && (sl == LV_AES || sl == LV_MIX);

  // admission decision for one command word
  always_comb begin
    ok_c       = 1'h0;
    layer_nxt  = layer_r;
    auth_nxt   = auth_r;
    pend_c     = 1'h0;
    pend_lvl_c = LV_AES;
    sw_c       = 1'h0;
    lcfg_c     = 1'h0;
    sess_c     = 1'h0;
    kw_c       = 4'h0;
    unique case (c.op)
      OP_FIELD: begin
        ok_c      = 1'h1;
        layer_nxt = LY_IDLE;
        auth_nxt  = AU_NONE;
      end
      OP_ANTICOL: begin
        ok_c = layer_r == LY_IDLE
               && c.arg[1:0] == (uid7_r ? CASC_7B : CASC_4B);
        layer_nxt = LY_L3;
      end
      OP_L4ACT: begin
        ok_c = l3 && !(leg && l4dis_r);
        layer_nxt = LY_L4;
      end
      OP_ISO: begin
        ok_c = l4 && (c.arg == INS_SELECT
                      || c.arg == INS_EXT_AUTH);
      end
      OP_VERSION, OP_READSIG: begin
        ok_c = pers ? act : l4;
      end
      OP_PWRITE: begin
        ok_c = pers && act;
        kw_c = 4'h1 << c.arg[1:0];
      end
      OP_PCOMMIT: begin
        ok_c = pers && act && keys_r[PK_CFG] && keys_r[PK_ROOT]
               && (keys_r[PK_SWITCH] || c.tgt == LV_AES)
               && (c.tgt == LV_LEG || c.tgt == LV_AES);
        pend_c     = 1'h1;
        pend_lvl_c = c.tgt;
      end
      OP_LAUTH: begin
        ok_c     = leg && l3 && sl_leg;
        auth_nxt = AU_LEG;
      end
      OP_AAUTH: begin
        sess_c = 1'h1;
        unique case (c.arg[1:0])
          KK_SECTOR: begin
            ok_c     = l4 && (aes ? sec_ok : sl_aes);
            auth_nxt = AU_AES;
          end
          KK_GENUINE: begin
            ok_c = pers ? act : l4;
          end
          KK_CARDAUTH: begin
            ok_c     = leg && l3;
            auth_nxt = AU_AESL;
          end
          KK_SWITCH: begin
            // either authenticate flavour, first flag ignored
            ok_c   = leg && l4;
            pend_c = 1'h1;
          end
        endcase
      end
      OP_LDATA: begin
        ok_c = leg && l3 && auth_r == AU_LEG
               && sl_leg;
      end
      OP_ADATA: begin
        ok_c = !pers && l4 && auth_r == AU_AES
               && sl_aes;
      end
      OP_SECSW: begin
        ok_c = leg && l4 && sec_ok && c.tgt != LV_PERS
               && c.tgt > sl;
        sw_c = 1'h1;
      end
      OP_KEYUPD: begin
        ok_c = !pers && l4 && (leg || auth_r == AU_AES);
      end
      OP_LCFG: begin
        // layer 3 too, else a disabled layer 4 could never be re-enabled
        ok_c   = leg && act;
        lcfg_c = 1'h1;
      end
      default: begin
        ok_c = 1'h0;
      end
    endcase
    if (c.wrap && !l4) begin
      ok_c = 1'h0;
    end
    if (!ok_c) begin
      layer_nxt = layer_r;
      auth_nxt  = auth_r;
      pend_c    = 1'h0;
      sw_c      = 1'h0;
      lcfg_c    = 1'h0;
      sess_c    = 1'h0;
      kw_c      = 4'h0;
    end
  end

  assign apply_c = ex && c.op == OP_FIELD && pend_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      layer_r <= LY_IDLE;
      auth_r  <= AU_NONE;
      sess_r  <= 2'h0;
    end else if (ex) begin
      layer_r <= layer_nxt;
      auth_r  <= auth_nxt;
      if (c.op == OP_FIELD) begin
        sess_r <= 2'h0;
      end else if (sess_c) begin
        sess_r <= 2'h3;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      card_lvl_r <= LV_PERS;
    end else if (apply_c) begin
      card_lvl_r <= pend_lvl_r;
    end else if (leg && min_c == LV_AES) begin
      card_lvl_r <= LV_AES;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend_r     <= 1'h0;
      pend_lvl_r <= LV_PERS;
    end else if (apply_c) begin
      pend_r <= 1'h0;
    end else if (ex && pend_c) begin
      pend_r     <= 1'h1;
      pend_lvl_r <= pend_lvl_c;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      keys_r  <= 3'h0;
      l4dis_r <= 1'h0;
    end else if (ex) begin
      keys_r <= keys_r | kw_c[2:0];
      if (lcfg_c) begin
        l4dis_r <= c.arg[0];
      end
    end
  end

  // reported level latched on a good anticollision
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      atq_r <= LV_PERS;
    end else if (ex && ok_c && c.op == OP_ANTICOL) begin
      if (atqhi_r) begin
        atq_r <= (max_c == LV_MIX) ? LV_AES : max_c;
      end else begin
        atq_r <= card_lvl_r;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ok_r  <= 1'h0;
      err_r <= 1'h0;
      acc_r <= 1'h0;
      rej_r <= 1'h0;
    end else begin
      acc_r <= ex && ok_c;
      rej_r <= ex && !ok_c;
      if (ex) begin
        ok_r  <= ok_c;
        err_r <= !ok_c;
      end
    end
  end

  for (genvar g = 0; g < NSEC; g++) begin : g_sec
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        sec_lvl_r[g] <= LV_PERS;
      end else if (apply_c) begin
        sec_lvl_r[g] <= pend_lvl_r;
      end else if (ex && sw_c && c.sec == 6'(g)) begin
        sec_lvl_r[g] <= c.tgt;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence cmd_s(slac_op_t o);
    ex && c.op == o;
  endsequence

  sequence commit_ok_s;
    cmd_s(OP_PCOMMIT) ##0 ok_c;
  endsequence

  sequence apply_s;
    pend_r ##0 cmd_s(OP_FIELD);
  endsequence

  iso_ins_a: assert property (
    cmd_s(OP_ISO) ##0 !l4 |=> cmd_reject)
    else $error("apdu command taken before layer 4");

  wrap_l4_a: assert property (
    ex && c.wrap && !l4 |=> cmd_reject && !cmd_accept)
    else $error("wrapped command taken before layer 4");

  no_down_a: assert property (
    card_lvl_r >= $past(card_lvl_r))
    else $error("card level went down");

  card_mix_a: assert property (
    card_lvl_r != LV_MIX)
    else $error("card-wide level is mixed");

  card_min_a: assert property (
    card_lvl_r <= min_c)
    else $error("card level above lowest sector");

  auto_raise_a: assert property (
    leg && min_c == LV_AES && !apply_c |=> card_lvl_r == LV_AES)
    else $error("card level not raised with sectors");

  atq_low_a: assert property (
    cmd_s(OP_ANTICOL) ##0 ok_c && !atqhi_r
    |=> atq_r == $past(card_lvl_r))
    else $error("reported level not the card level");

  anticol_a: assert property (
    cmd_s(OP_ANTICOL) ##0 uid7_r && c.arg[1:0] == CASC_4B
    |=> cmd_reject && layer_r == LY_IDLE)
    else $error("short cascade accepted for long id");

  commit_wait_a: assert property (
    commit_ok_s |=> pend_r && card_lvl_r == LV_PERS)
    else $error("commit took effect before reactivation");

  apply_a: assert property (
    apply_s |=> card_lvl_r == $past(pend_lvl_r) && !pend_r)
    else $error("pending level not applied");

  commit_key_a: assert property (
    cmd_s(OP_PCOMMIT) ##0 !keys_r[PK_ROOT] |=> cmd_reject)
    else $error("commit without root key");

  l4_off_a: assert property (
    cmd_s(OP_L4ACT) ##0 leg && l4dis_r && l3
    |=> cmd_reject && layer_r == LY_L3)
    else $error("layer 4 taken while disabled");

  aes_l3_a: assert property (
    cmd_s(OP_LDATA) ##0 aes |=> cmd_reject)
    else $error("legacy data taken in aes level");

  reject_hold_a: assert property (
    ex && !ok_c |=> $stable(layer_r) && $stable(auth_r)
                    && $stable(pend_r) && err_r)
    else $error("rejected command changed state");

endmodule

/* verilog/slac_pkg.sv */
// constants, command and status layouts for the access control block
// assumes one 10 MHz clock and a word-aligned avalon-mm register bus
package slac_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_CMD    = 8'h04;
  localparam logic [7:0] OFF_STAT   = 8'h08;
  localparam logic [7:0] OFF_SECSEL = 8'h0C;
  localparam logic [7:0] OFF_SECLVL = 8'h10;

  // control fields and reset values
  localparam int unsigned CTRL_UID7  = 0;
  localparam int unsigned CTRL_ATQHI = 1;
  localparam logic       CTRL_RST   = 1'h0;
  localparam logic [5:0] SECSEL_RST = 6'h00;

  // security levels, ordered low to high
  localparam logic [1:0] LV_PERS = 2'h0;
  localparam logic [1:0] LV_LEG  = 2'h1;
  localparam logic [1:0] LV_MIX  = 2'h2;
  localparam logic [1:0] LV_AES  = 2'h3;

  // aes authentication key kinds
  localparam logic [1:0] KK_SECTOR   = 2'h0;
  localparam logic [1:0] KK_GENUINE  = 2'h1;
  localparam logic [1:0] KK_CARDAUTH = 2'h2;
  localparam logic [1:0] KK_SWITCH   = 2'h3;

  // personalization write targets
  localparam logic [1:0] PK_CFG    = 2'h0;
  localparam logic [1:0] PK_ROOT   = 2'h1;
  localparam logic [1:0] PK_SWITCH = 2'h2;
  localparam logic [1:0] PK_DATA   = 2'h3;

  // apdu instruction bytes and cascade counts
  localparam logic [7:0] INS_SELECT   = 8'hA4;
  localparam logic [7:0] INS_EXT_AUTH = 8'h82;
  localparam logic [1:0] CASC_4B      = 2'h1;
  localparam logic [1:0] CASC_7B      = 2'h2;

  typedef enum logic [3:0] {
    OP_FIELD   = 4'h0,
    OP_ANTICOL = 4'h1,
    OP_L4ACT   = 4'h2,
    OP_ISO     = 4'h3,
    OP_VERSION = 4'h4,
    OP_READSIG = 4'h5,
    OP_PWRITE  = 4'h6,
    OP_PCOMMIT = 4'h7,
    OP_LAUTH   = 4'h8,
    OP_AAUTH   = 4'h9,
    OP_LDATA   = 4'hA,
    OP_ADATA   = 4'hB,
    OP_SECSW   = 4'hC,
    OP_KEYUPD  = 4'hD,
    OP_LCFG    = 4'hE
  } slac_op_t;

  typedef enum logic [2:0] {
    LY_IDLE = 3'h1,
    LY_L3   = 3'h2,
    LY_L4   = 3'h4
  } slac_layer_t;

  typedef enum logic [3:0] {
    AU_NONE = 4'h1,
    AU_LEG  = 4'h2,
    AU_AESL = 4'h4,
    AU_AES  = 4'h8
  } slac_auth_t;

  typedef struct packed {
    logic [7:0] arg;
    logic [1:0] tgt;
    logic [5:0] sec;
    logic [1:0] rsv;
    logic       first;
    logic       wrap;
    slac_op_t   op;
  } slac_cmd_t;

  typedef struct packed {
    logic [1:0]  sess;
    logic [1:0]  atq;
    logic [1:0]  plvl;
    logic        pend;
    logic        l4dis;
    slac_auth_t  auth;
    slac_layer_t layer;
    logic [1:0]  card;
    logic        err;
    logic        ok;
  } slac_stat_t;

  localparam int unsigned STAT_PAD = DATA_W - $bits(slac_stat_t);

endpackage

/* dv/slac_reader.sv */
// reader model: avalon-mm master that carries card events as words
// assumes the bench calls xfer one access at a time
`timescale 1ns/10ps
module slac_reader
  import slac_pkg::*;
(
  // clock
  input  wire logic              clk,
  // avalon-mm master
  output logic      [ADDR_W-1:0] address,
  output logic                   read,
  output logic                   write,
  output logic      [DATA_W-1:0] writedata,
  output logic      [3:0]        byteenable,
  input  wire logic [DATA_W-1:0] readdata,
  input  wire logic              waitrequest
);
  initial begin
    address    = '0;
    read       = 1'b0;
    write      = 1'b0;
    writedata  = '0;
    byteenable = 4'h0;
  end

  // one access, held until waitrequest is seen low at an edge
  task automatic xfer(input logic rd, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] q);
    @(posedge clk);
    address    <= a;
    writedata  <= d;
    byteenable <= be;
    read       <= rd;
    write      <= ~rd;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    read      <= 1'b0;
    write     <= 1'b0;
    // released data lines must not keep the old value
    writedata <= ~d;
  endtask
endmodule

/* dv/security_level_access_control_tb_top.sv */
// bench: reader model sends card events, integer model predicts outcome
// assumes slac_core built with two sectors and a 10 MHz clock
`timescale 1ns/10ps
module security_level_access_control_tb_top
  import slac_pkg::*;
;
  logic              clk;
  logic              nrst;
  logic [ADDR_W-1:0] address;
  logic              read;
  logic              write;
  logic [DATA_W-1:0] writedata;
  logic [3:0]        byteenable;
  logic [DATA_W-1:0] readdata;
  logic              waitrequest;
  logic [1:0]        card_level;
  logic [1:0]        atq_level;
  logic              l4_active;
  logic              cmd_accept;
  logic              cmd_reject;
  logic [31:0]       q;
  logic [31:0]       seed = 32'h9E22;
  logic [3:0]        keys = 4'h0;
  int                n_mismatch = 0;
  int                total_checks = 0;
  int                cyc = 0;
  int                clv = 0;
  int                pend = -1;
  int                lay = 0;
  int                au = 0;
  int                l4d = 0;
  int                u7 = 0;
  int                ah = 0;
  int                atq = 0;
  int                sess = 0;
  int                slv[2] = '{0, 0};
  int                ins[3] = '{'hA4, 'h82, 'hB0};

  slac_core #(.NSEC(2)) u_slac_core (
    .clk        (clk),
    .nrst       (nrst),
    .address    (address),
    .read       (read),
    .write      (write),
    .writedata  (writedata),
    .byteenable (byteenable),
    .readdata   (readdata),
    .waitrequest(waitrequest),
    .card_level (card_level),
    .atq_level  (atq_level),
    .l4_active  (l4_active),
    .cmd_accept (cmd_accept),
    .cmd_reject (cmd_reject)
  );

  slac_reader u_slac_reader (
    .clk        (clk),
    .address    (address),
    .read       (read),
    .write      (write),
    .writedata  (writedata),
    .byteenable (byteenable),
    .readdata   (readdata),
    .waitrequest(waitrequest)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] nxt(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // card state model; returns whether the event is taken
  function automatic bit mdl(int op, int a, int t, int s, bit w);
    bit ok;
    int mn;
    int mx;
    mn = slv[0] < slv[1] ? slv[0] : slv[1];
    mx = slv[0] < slv[1] ? slv[1] : slv[0];
    if (w && lay != 2)
      return 1'b0;
    case (op)
      0: ok = 1'b1;
      1: ok = lay == 0 && a == (u7 ? 2 : 1);
      2: ok = lay == 1 && !(clv == 1 && l4d == 1);
      3: ok = lay == 2 && (a == 'hA4 || a == 'h82);
      4, 5: ok = clv == 0 ? lay > 0 : lay == 2;
      6: ok = clv == 0 && lay > 0;
      7: ok = clv == 0 && lay > 0 && keys[1:0] == 2'h3 &&
              (t == 3 || (t == 1 && keys[2]));
      8: ok = clv == 1 && lay == 1 && slv[s] < 3;
      9: ok = a == 0 ? lay == 2 && slv[s] >= 2 :
              a == 1 ? (clv == 0 ? lay > 0 : lay == 2) :
              a == 2 ? clv == 1 && lay == 1 :
              clv == 1 && lay == 2;
      10: ok = au == 1 && lay == 1 && clv == 1 &&
               slv[s] > 0 && slv[s] < 3;
      11: ok = au == 3 && lay == 2 && slv[s] >= 2;
      12: ok = clv == 1 && lay == 2 && t > slv[s];
      13: ok = clv != 0 && lay == 2 && (clv == 1 || au == 3);
      14: ok = clv == 1 && lay > 0;
      default: ok = 1'b0;
    endcase
    if (!ok)
      return 1'b0;
    case (op)
      0: begin
        lay = 0;
        au = 0;
        sess = 0;
        if (pend >= 0) slv = '{pend, pend};
        if (pend >= 0) clv = pend;
        pend = -1;
      end
      1: begin
        lay = 1;
        atq = ah ? mx : mn;
      end
      2: lay = 2;
      6: keys[a] = 1'b1;
      7: pend = t;
      8: au = 1;
      9: begin
        sess = 3;
        if (a == 0) au = 3;
        if (a == 2) au = 2;
        if (a == 3) pend = 3;
      end
      12: slv[s] = t;
      14: l4d = a % 2;
      default: ;
    endcase
    if (slv[0] == 3 && slv[1] == 3) clv = 3;
    return 1'b1;
  endfunction

  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cmd(int op, int a = 0, int t = 0, int s = 0, bit w = 0,
                     bit f = 0);
    slac_cmd_t c;
    logic      ok;
    c      = '0;
    c.op   = slac_op_t'(4'(op));
    c.wrap = w;
    c.first = f;
    c.sec  = 6'(s);
    c.tgt  = 2'(t);
    c.arg  = 8'(a);
    ok     = mdl(op, a, t, s, w);
    u_slac_reader.xfer(1'b0, OFF_CMD, {8'h00, c}, 4'hF, q);
    @(negedge clk);
    chk(cmd_accept, ok);
    chk(cmd_reject, !ok);
    @(negedge clk);
    chk(card_level, clv);
    chk(l4_active, lay == 2);
    if (op == 1)
      chk(atq_level, atq);
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m);
    u_slac_reader.xfer(1'b1, a, 32'h0, 4'hF, q);
    chk(q & m, e);
  endtask

  task automatic wr(logic [7:0] a, int d);
    u_slac_reader.xfer(1'b0, a, 32'(d), 4'h1, q);
  endtask

  task automatic act(bit l4);
    cmd(0);
    cmd(1, u7 ? 2 : 1);
    if (l4)
      cmd(2);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  initial begin
    nrst = 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk(waitrequest, 1'b1);
    chk(card_level, 2'h0);
    chk(l4_active, 1'b0);
    rd(OFF_STAT, 32'h90, 32'h7FC);
    // cascade count follows the id length
    u7 = 1;
    wr(OFF_CTRL, 1);
    cmd(0);
    cmd(1, 1);
    cmd(1, 2);
    u7 = 0;
    wr(OFF_CTRL, 0);
    act(0);
    // personalization level
    cmd(4);
    cmd(9, 1);
    cmd(8, 0, 0, 1);
    cmd(7, 0, 1);
    cmd(6, 0);
    cmd(6, 1);
    cmd(6, 3);
    cmd(7, 0, 1);
    cmd(7, 0, 2);
    cmd(6, 2);
    cmd(7, 0, 1);
    act(1);
    // legacy level, layer 4
    foreach (ins[i])
      cmd(3, ins[i]);
    cmd(4, 0, 0, 0, 1);
    cmd(12, 0, 2, 0);
    cmd(12, 0, 1, 0);
    cmd(9, 0, 0, 0);
    cmd(13);
    wr(OFF_SECSEL, 0);
    rd(OFF_SECLVL, 32'h2, 32'h3);
    // legacy level, layer 3
    act(0);
    cmd(4, 0, 0, 0, 1);
    cmd(3, 'hA4);
    cmd(9, 3);
    cmd(13);
    cmd(10);
    cmd(8, 0, 0, 0);
    cmd(10);
    cmd(9, 2);
    cmd(10);
    cmd(8, 0, 0, 1);
    cmd(10);
    // sector raise keeps the card at the lowest level
    act(1);
    cmd(12, 0, 3, 0);
    act(0);
    cmd(8, 0, 0, 0);
    cmd(14, 1);
    act(1);
    ah = 1;
    wr(OFF_CTRL, 2);
    act(0);
    cmd(14, 0);
    act(1);
    cmd(9, 3, 0, 0, 0, 1);
    cmd(9, 3);
    act(1);
    // aes level
    cmd(11);
    cmd(9, 0, 0, 1);
    cmd(11);
    cmd(13);
    rd(OFF_STAT, 32'h44C | (32'(sess) << 17), 32'h607FC);
    cmd(12, 0, 1, 1);
    act(0);
    cmd(8, 0, 0, 1);
    cmd(10);
    seed = nxt(seed);
    cmd(15, seed[7:0]);
    u_slac_reader.xfer(1'b0, OFF_CMD, 32'h4, 4'h7, q);
    @(negedge clk);
    chk({cmd_accept, cmd_reject}, 2'h0);
    seed = nxt(seed);
    rd(8'(20 + 4 * (seed % 59)), 32'h0, '1);
    end_of_test();
  end
endmodule
